// ===== tcc_pkg.sv
// Notes on behaviour
// - A register read-write match, B read-only capture
// - reset loads A and B with all ones
// - control defined bits reset to zero, stopped
// - timer, event counter and capture modes
// - one mode bit: timer/event or capture
// - codes 000-110 pick high clock taps 2^13..2^7
// - code 111 counts the external count pin in timer/event mode
// - low-speed select or slow: low clock taps for codes 000-100
// - stop-mode entry clears run bit automatically
// - control bits 5 and 7 read don't-care
// - timer mode increments per tick, restarts zero
// - match raises interrupt and clears counter
// - auto-capture copies live count into B
// - zero after match clear not captured
// - event mode counts rising, matches on falling
// - capture mode: fall to B, rise to A
package tcc_pkg;
	localparam logic [7:0] OFF_A = 8'h10;
	localparam logic [7:0] OFF_B = 8'h11;
	localparam logic [7:0] OFF_CTRL = 8'h12;
	localparam logic [7:0] DATA_RESET = 8'hff;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'h5f;
	localparam int BIT_AUTO_CAPTURE_ENABLE = 6;
	localparam int BIT_RUN = 4;
	localparam int BIT_CK_LO = 1;
	localparam int BIT_MODE = 0;
	localparam logic [2:0] CK_EXT = 3'h7;
	localparam int PRE_W = 14;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic auto_capture_enable;
		logic run;
		logic [2:0] ck;
		logic mode;
	} tcc_ctrl_t;
endpackage

// ===== tcc_tick_sel.sv
`timescale 1ns/100ps
// source clock tap selection, one pulse per selected tick
module tcc_tick_sel (
	input wire logic aclk, // system clock
	input wire logic aresetn, // sync reset, active low
	input wire logic [2:0] ck, // source clock select code
	input wire logic low_sel, // low-speed prescale select or slow mode
	input wire logic [13:0] hi_div, // high clock prescaler taps
	input wire logic [5:0] lo_div, // low clock prescaler taps
	output logic tick // registered tick pulse
);
	logic [13:0] hi_q;
	logic [5:0] lo_q;
	logic lvl;
	logic lvl_q;
	// pick the tap level for the code; codes 101/110 stay high-clock taps
	always_comb begin
		lvl = 1'b0;
		if (low_sel && ck <= 3'h4) begin
			lvl = lo_q[3'h4 - ck];
		end else if (ck != tcc_pkg::CK_EXT) begin
			lvl = hi_q[4'hc - {1'b0, ck}];
		end
	end
	// rising edge of the tap gives a tick
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hi_q <= '0;
			lo_q <= '0;
			lvl_q <= 1'b0;
			tick <= 1'b0;
		end else begin
			hi_q <= hi_div;
			lo_q <= lo_div;
			// compare with the level one cycle earlier, so each tap rise gives one tick
			lvl_q <= lvl;
			tick <= lvl & ~lvl_q;
		end
	end
	a_tick_ext_none: assert property (@(posedge aclk) disable iff (!aresetn)
		(ck == tcc_pkg::CK_EXT) [*2] |-> !tick) else $error("tick on external code");
endmodule

// ===== tcc_timer.sv
`timescale 1ns/100ps
module tcc_timer (
	input wire logic aclk, // system clock
	input wire logic aresetn, // sync reset, active low
	input wire logic [31:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [31:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read valid
	input wire logic s_axi_rready, // read ready
	input wire logic [13:0] high_freq_div, // high clock prescaler taps
	input wire logic [5:0] low_freq_div, // low clock prescaler taps
	input wire logic low_speed_prescale_select, // low clock taps for codes 000-100 in normal mode
	input wire logic slow_mode, // chip in slow or sleep mode
	input wire logic stop_mode_entry, // pulse on entry to stop mode
	input wire logic count_input_pin, // external count / capture input
	output logic match_interrupt // one-cycle interrupt request pulse
);
	logic [7:0] match_capture_a_reg;
	logic [7:0] capture_b_reg;
	tcc_pkg::tcc_ctrl_t ctrl_reg;
	logic [7:0] count_reg;
	logic [7:0] count_next;
	logic pin_q_reg;
	logic cap_first_reg;
	logic ovf_hold_reg;
	logic zero_after_clr_reg;
	logic match_pend_reg;
	logic tick;
	logic pin_rise;
	logic pin_fall;
	logic aw_hold_reg;
	logic w_hold_reg;
	logic [7:0] awaddr_reg;
	logic [7:0] wdata_reg;
	logic wstrb0_reg;
	logic wr_go;
	logic wr_a;
	logic wr_ctrl;
	logic rd_a;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == tcc_pkg::OFF_A) || (a == tcc_pkg::OFF_B) || (a == tcc_pkg::OFF_CTRL);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// write channel: address and data taken in either order, response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb0_reg <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= tcc_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_hold_reg && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= !w_hold_reg && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr[9:2];
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_reg <= 1'b1;
				wdata_reg <= s_axi_wdata[7:0];
				wstrb0_reg <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(awaddr_reg) ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	assign wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
	assign wr_a = wr_go && wstrb0_reg && awaddr_reg == tcc_pkg::OFF_A;
	assign wr_ctrl = wr_go && wstrb0_reg && awaddr_reg == tcc_pkg::OFF_CTRL;

	////////////////////////////////////////////////////////////////////////////////
	// read channel; byte address is four times the printed offset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= tcc_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= mapped(s_axi_araddr[9:2]) ? tcc_pkg::RESP_OKAY
					: tcc_pkg::RESP_SLVERR;
				case (s_axi_araddr[9:2])
					tcc_pkg::OFF_A: s_axi_rdata <= {24'h0, match_capture_a_reg};
					tcc_pkg::OFF_B: s_axi_rdata <= {24'h0, capture_b_reg};
					// bits 5 and 7 read as zero, a legal don't-care value
					tcc_pkg::OFF_CTRL: s_axi_rdata <= {24'h0, 1'b0, ctrl_reg.auto_capture_enable, 1'b0,
						ctrl_reg.run, ctrl_reg.ck, ctrl_reg.mode};
					default: s_axi_rdata <= '0;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
	assign rd_a = s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] == tcc_pkg::OFF_A;

	////////////////////////////////////////////////////////////////////////////////
	// control register; stop mode entry drops the run bit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= tcc_pkg::tcc_ctrl_t'(tcc_pkg::CTRL_RESET[5:0]);
		end else if (wr_ctrl) begin
			// mode/source written while running are taken anyway; software keeps them still
			ctrl_reg.auto_capture_enable <= wdata_reg[tcc_pkg::BIT_AUTO_CAPTURE_ENABLE];
			ctrl_reg.run <= wdata_reg[tcc_pkg::BIT_RUN] && !stop_mode_entry;
			ctrl_reg.ck <= wdata_reg[tcc_pkg::BIT_CK_LO +: 3];
			ctrl_reg.mode <= wdata_reg[tcc_pkg::BIT_MODE];
		end else if (stop_mode_entry) begin
			ctrl_reg.run <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// tick source and pin edges
	tcc_tick_sel u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.ck(ctrl_reg.ck),
		.low_sel(low_speed_prescale_select || slow_mode),
		.hi_div(high_freq_div),
		.lo_div(low_freq_div),
		.tick(tick)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_q_reg <= 1'b0;
		end else begin
			pin_q_reg <= count_input_pin;
		end
	end
	assign pin_rise = count_input_pin && !pin_q_reg;
	assign pin_fall = !count_input_pin && pin_q_reg;

	////////////////////////////////////////////////////////////////////////////////
	// up-counter, match and capture state
	// event mode is code 111 in timer/event mode; match waits for the falling edge
	always_comb begin
		count_next = count_reg;
		if (!ctrl_reg.run) begin
			count_next = '0;
		end else if (ctrl_reg.mode) begin
			if (pin_rise && !ovf_hold_reg) begin
				count_next = '0;
			end else if (count_reg == 8'hff && tick && !ovf_hold_reg) begin
				count_next = '0;
			end else if (tick) begin
				count_next = count_reg + 8'h01;
			end
		end else if (ctrl_reg.ck == tcc_pkg::CK_EXT) begin
			if (pin_fall && match_pend_reg) begin
				count_next = '0;
			end else if (pin_rise && !match_pend_reg) begin
				count_next = count_reg + 8'h01;
			end
		end else if (tick) begin
			if (count_reg == match_capture_a_reg) begin
				count_next = '0;
			end else begin
				count_next = count_reg + 8'h01;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

	// event mode: a match seen after a rising edge is flagged until the falling edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			match_pend_reg <= 1'b0;
		end else if (!ctrl_reg.run || ctrl_reg.mode || ctrl_reg.ck != tcc_pkg::CK_EXT) begin
			match_pend_reg <= 1'b0;
		end else if (pin_fall && match_pend_reg) begin
			match_pend_reg <= 1'b0;
		end else if (count_reg == match_capture_a_reg && count_reg != 8'h00) begin
			match_pend_reg <= 1'b1;
		end
	end

	// interrupt pulse: timer match, event match on fall, capture rise or overflow
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			match_interrupt <= 1'b0;
		end else if (!ctrl_reg.run) begin
			match_interrupt <= 1'b0;
		end else if (ctrl_reg.mode) begin
			match_interrupt <= !ovf_hold_reg && (pin_rise || (tick && count_reg == 8'hff));
		end else if (ctrl_reg.ck == tcc_pkg::CK_EXT) begin
			match_interrupt <= pin_fall && match_pend_reg;
		end else begin
			match_interrupt <= tick && count_reg == match_capture_a_reg;
		end
	end

	// the cleared zero after a match is not copied by auto-capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			zero_after_clr_reg <= 1'b0;
		end else if (count_next == 8'h00 && count_reg != 8'h00) begin
			zero_after_clr_reg <= 1'b1;
		end else if (count_next != 8'h00) begin
			zero_after_clr_reg <= 1'b0;
		end
	end

	// capture mode first-edge and overflow hold state; reading A releases the hold
	always_ff @(posedge aclk) begin
		if (!aresetn || !ctrl_reg.run || !ctrl_reg.mode) begin
			cap_first_reg <= 1'b1;
			ovf_hold_reg <= 1'b0;
		end else begin
			if (pin_fall || pin_rise) begin
				cap_first_reg <= 1'b0;
			end
			if (rd_a) begin
				ovf_hold_reg <= 1'b0;
			end else if (tick && count_reg == 8'hff && !pin_rise && !ovf_hold_reg) begin
				ovf_hold_reg <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// data registers A and B
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			match_capture_a_reg <= tcc_pkg::DATA_RESET;
		end else if (ctrl_reg.run && ctrl_reg.mode && !ovf_hold_reg && pin_rise) begin
			match_capture_a_reg <= count_reg;
		end else if (ctrl_reg.run && ctrl_reg.mode && !ovf_hold_reg && tick && count_reg == 8'hff) begin
			match_capture_a_reg <= tcc_pkg::DATA_RESET;
		end else if (wr_a) begin
			match_capture_a_reg <= wdata_reg;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			capture_b_reg <= tcc_pkg::DATA_RESET;
		end else if (ctrl_reg.run && ctrl_reg.mode) begin
			if (pin_fall && !ovf_hold_reg) begin
				capture_b_reg <= count_reg;
			end
		end else if (ctrl_reg.auto_capture_enable && !(count_reg == 8'h00 && zero_after_clr_reg)) begin
			capture_b_reg <= count_reg;
		end
	end

	a_stop_clears_run: assert property (@(posedge aclk) disable iff (!aresetn)
		stop_mode_entry |=> !ctrl_reg.run) else $error("run survived stop entry");
	a_run_off_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		!ctrl_reg.run |=> count_reg == 8'h00) else $error("counter not cleared when stopped");
	a_timer_match_irq: assert property (@(posedge aclk) disable iff (!aresetn)
		(ctrl_reg.run && !ctrl_reg.mode && ctrl_reg.ck != tcc_pkg::CK_EXT && tick
		&& count_reg == match_capture_a_reg && !stop_mode_entry && !wr_ctrl)
		|=> match_interrupt && count_reg == 8'h00) else $error("timer match missed");
	a_timer_count_up: assert property (@(posedge aclk) disable iff (!aresetn)
		(ctrl_reg.run && !ctrl_reg.mode && ctrl_reg.ck != tcc_pkg::CK_EXT && tick
		&& count_reg != match_capture_a_reg && !stop_mode_entry && !wr_ctrl)
		|=> count_reg == $past(count_reg) + 8'h01) else $error("timer did not count");
	a_auto_capture_enable_no_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(!ctrl_reg.mode && zero_after_clr_reg && count_reg == 8'h00)
		|=> $stable(capture_b_reg)) else $error("cleared zero captured");
	a_auto_capture_enable_follows: assert property (@(posedge aclk) disable iff (!aresetn)
		(ctrl_reg.auto_capture_enable && !ctrl_reg.mode && count_reg != 8'h00)
		|=> capture_b_reg == $past(count_reg)) else $error("auto-capture lagging");
	a_ctrl_rsvd_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_axi_rvalid && !$past(s_axi_rvalid) && $past(s_axi_araddr[9:2]) == tcc_pkg::OFF_CTRL)
		|-> s_axi_rdata[7] == 1'b0 && s_axi_rdata[5] == 1'b0)
		else $error("reserved bits set");
	a_event_irq_fall: assert property (@(posedge aclk) disable iff (!aresetn)
		(match_interrupt && !ctrl_reg.mode && ctrl_reg.ck == tcc_pkg::CK_EXT)
		|-> $past(pin_fall)) else $error("event interrupt not on falling edge");
	a_capture_rise_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(ctrl_reg.run && ctrl_reg.mode && !ovf_hold_reg && pin_rise && !stop_mode_entry && !wr_ctrl)
		|=> match_interrupt && match_capture_a_reg == $past(count_reg))
		else $error("capture rise mishandled");
endmodule

// ===== tcc_far.sv
`timescale 1ns/100ps
// far side: free-running prescaler chains and the external pulse source
module tcc_far (
	input wire logic aclk, // system clock
	input wire logic aresetn, // sync reset, active low
	output logic [13:0] high_freq_div, // high clock taps
	output logic [5:0] low_freq_div, // low clock taps
	output logic count_input_pin // external count pulse
);
	logic [1:0] lo_pre;
	// high chain steps every cycle; low chain every fourth, a slower clock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			high_freq_div <= 14'h0;
			low_freq_div <= 6'h0;
			lo_pre <= 2'h0;
		end else begin
			high_freq_div <= high_freq_div + 14'h1;
			lo_pre <= lo_pre + 2'h1;
			if (lo_pre == 2'h3)
				low_freq_div <= low_freq_div + 6'h1;
		end
	end
	initial count_input_pin = 1'b0;
	// each level stands several cycles, well above the minimum pulse width
	task automatic drive_pin(input logic v, input int hold);
		@(posedge aclk);
		count_input_pin <= v;
		repeat (hold) @(posedge aclk);
	endtask
endmodule

// ===== eight_bit_timer_counter_capture_tb.sv
`timescale 1ns/100ps
module eight_bit_timer_counter_capture_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
	logic awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid, bready = 1'b0;
	logic arvalid = 1'b0, arready, rvalid, rready = 1'b0, irq;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp, rsp;
	logic [13:0] hdiv;
	logic [5:0] ldiv;
	logic pin, low_sel = 1'b0, slow = 1'b0, stop_in = 1'b0;
	logic [31:0] v;
	int n_fail = 0, n_checks = 0, n_irq = 0, c, base;
	logic [2:0] ck_tab [4] = '{3'h6, 3'h5, 3'h4, 3'h3};
	logic lo_tab [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
	logic sl_tab [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
	int tk_tab [4] = '{128, 256, 8, 16};

	always #50 aclk = ~aclk;
	always @(posedge aclk) if (irq === 1'b1) n_irq++;

	tcc_far u_far (.aclk(aclk), .aresetn(aresetn), .high_freq_div(hdiv),
		.low_freq_div(ldiv), .count_input_pin(pin));
	tcc_timer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .high_freq_div(hdiv), .low_freq_div(ldiv),
		.low_speed_prescale_select(low_sel), .slow_mode(slow),
		.stop_mode_entry(stop_in), .count_input_pin(pin), .match_interrupt(irq));

	////////////////////////////////////////////////////////////////////////////
	// compare and count; a mismatch is reported at once
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// write master: each channel released as it is taken, bready held until bvalid
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				rsp = bresp;
				bready <= 1'b0;
				break;
			end
			if (++t > 1000) begin
				chk("write_timeout", 0, 1);
				break;
			end
		end
	endtask

	// read master: rready held until rvalid, data taken at that edge
	task automatic rd(input logic [31:0] a);
		int t;
		t = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				v = rdata;
				rsp = rresp;
				rready <= 1'b0;
				break;
			end
			if (++t > 1000) begin
				chk("read_timeout", 0, 1);
				break;
			end
		end
	endtask

	// cycles from the current edge to the next interrupt pulse, bounded
	task automatic wait_irq();
		c = 0;
		do begin
			@(posedge aclk);
			c++;
		end while (irq !== 1'b1 && c < 5000);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// a hang is cut short well past the expected run length
	initial begin
		repeat (60000) @(posedge aclk);
		n_fail++;
		tally_and_finish();
	end

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		// reset values, read-only B, unmapped word
		rd(32'h40); chk("a_reset", 32'hff, v);
		rd(32'h44); chk("b_reset", 32'hff, v);
		rd(32'h48); chk("ctrl_reset", 32'h0, v);
		wr(32'h44, 32'h12); rd(32'h44); chk("b_readonly", 32'hff, v);
		rd(32'h50); chk("unmapped_resp", 32'h2, {30'h0, rsp});
		chk("unmapped_data", 32'h0, v);
		$display("test registers done");
		// tick period for four clock sources: A=2 gives three ticks per match
		for (int i = 0; i < 4; i++) begin
			wr(32'h48, {28'h0, ck_tab[i], 1'b0});
			low_sel <= lo_tab[i];
			slow <= sl_tab[i];
			wr(32'h40, 32'h2);
			wr(32'h48, {25'h0, 1'b1, 1'b0, 1'b1, ck_tab[i], 1'b0});
			wait_irq();
			wait_irq(); chk("match_period", 3 * tk_tab[i], c);
			rd(32'h44); chk("live_count", 1, (v >= 1 && v <= 2));
			wr(32'h48, {28'h0, ck_tab[i], 1'b0});
		end
		low_sel <= 1'b0;
		slow <= 1'b0;
		$display("test timer done");
		// loose bits and automatic stop
		wr(32'h48, 32'hff); rd(32'h48); chk("ctrl_loose", 32'h5f, v);
		@(posedge aclk) stop_in <= 1'b1;
		@(posedge aclk) stop_in <= 1'b0;
		rd(32'h48); chk("stop_clears_run", 32'h4f, v);
		wr(32'h48, 32'h0);
		$display("test stop done");
		// event counting: interrupt only on the fall after the match
		wr(32'h48, 32'h0e);
		wr(32'h40, 32'h2);
		wr(32'h48, 32'h1e);
		base = n_irq;
		u_far.drive_pin(1'b1, 4);
		u_far.drive_pin(1'b0, 4);
		u_far.drive_pin(1'b1, 6); chk("no_irq_on_rise", base, n_irq);
		u_far.drive_pin(1'b0, 6); chk("irq_on_fall", base + 1, n_irq);
		wr(32'h48, 32'h0e);
		$display("test event done");
		// capture: rise before any fall updates A; then fall to B, rise to A
		wr(32'h48, 32'h0d);
		wr(32'h48, 32'h1d);
		base = n_irq;
		repeat (1000) @(posedge aclk);
		u_far.drive_pin(1'b1, 640);
		rd(32'h40); chk("first_rise_a", 1, (v >= 6 && v <= 9));
		u_far.drive_pin(1'b0, 640);
		u_far.drive_pin(1'b1, 20);
		rd(32'h44); chk("fall_to_b", 1, (v >= 4 && v <= 6));
		rd(32'h40); chk("rise_to_a", 1, (v >= 9 && v <= 11));
		chk("capture_irqs", base + 2, n_irq);
		wr(32'h48, 32'h0c);
		$display("test capture done");
		tally_and_finish();
	end
endmodule
